//--- rapc_regs.svh
// Register offsets, field positions, reset values and time constants
// Assumes inclusion by bare name from the block's source files
`ifndef RAPC_REGS_SVH
`define RAPC_REGS_SVH

// Register offsets on the control port
`define RAPC_ADDR_ATTACK 7'h69
`define RAPC_ADDR_DECAY 7'h6a
`define RAPC_ADDR_PATH 7'h6b
`define RAPC_ADDR_BYPASS 7'h6c

// Reset values and writable masks
`define RAPC_RST_ATTACK 8'h00
`define RAPC_RST_DECAY 8'h00
`define RAPC_RST_PATH 8'h00
`define RAPC_RST_BYPASS 8'h00
`define RAPC_PATH_WMASK 8'hfc
`define RAPC_BYPASS_WMASK 8'hc0
`define RAPC_RD_NONE 8'h00

// Attack and decay field positions
`define RAPC_SEL_BIT 7
`define RAPC_BASE_HI 6
`define RAPC_BASE_LO 5
`define RAPC_MULT_HI 4
`define RAPC_MULT_LO 2

// Path and bus-condition field positions
`define RAPC_HIPASS_L_BIT 7
`define RAPC_HIPASS_R_BIT 6
`define RAPC_MIC_HI 5
`define RAPC_MIC_LO 4
`define RAPC_PFILT_BIT 3
`define RAPC_BUSDET_BIT 2
`define RAPC_RSVD_BIT 1
`define RAPC_BUSERR_BIT 0

// Bypass switch field positions
`define RAPC_BYP_M_BIT 7
`define RAPC_BYP_P_BIT 6

// Baseline times in ms
`define RAPC_ATT_MS_0 16'h0007
`define RAPC_ATT_MS_1 16'h0008
`define RAPC_ATT_MS_2 16'h000a
`define RAPC_ATT_MS_3 16'h000b
`define RAPC_DEC_MS_0 16'h0032
`define RAPC_DEC_MS_1 16'h0096
`define RAPC_DEC_MS_2 16'h00fa
`define RAPC_DEC_MS_3 16'h015e

// Decay caps in ms, by decimation ratio given in half steps
`define RAPC_CAP_R1 16'h0fa0
`define RAPC_CAP_R1_5 16'h15e0
`define RAPC_CAP_R2 16'h1f40
`define RAPC_CAP_R2_5 16'h2580
`define RAPC_CAP_R3 16'h2bc0
`define RAPC_CAP_R4 16'h3e80
`define RAPC_CAP_R5 16'h4b00
`define RAPC_CAP_R5_5 16'h5780
`define RAPC_NOCAP 16'hffff
`define RAPC_DR_1 4'h2
`define RAPC_DR_1_5 4'h3
`define RAPC_DR_2 4'h4
`define RAPC_DR_2_5 4'h5
`define RAPC_DR_3 4'h6
`define RAPC_DR_3_5 4'h7
`define RAPC_DR_4 4'h8
`define RAPC_DR_4_5 4'h9
`define RAPC_DR_5 4'ha

`endif

//--- rapc_pkg.sv
// Types shared by the right AGC and ADC path configuration block
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rapc_pkg;

    // Microphone type selection of the decimation filter
    typedef enum logic [1:0] {
        RAPC_MIC_DD = 2'h0,
        RAPC_MIC_DA = 2'h1,
        RAPC_MIC_AD = 2'h2,
        RAPC_MIC_AA = 2'h3
    } rapc_mic_cfg_t;

    // Whole state of the configuration block
    typedef struct packed {
        logic [7:0] attack_reg;
        logic [7:0] decay_reg;
        logic [7:0] path_reg;
        logic [7:0] bypass_reg;
        logic err_sts;
        logic [7:0] rdata;
        logic [15:0] attack_ms;
        logic [15:0] decay_ms;
        logic hipass_l_prog;
        logic hipass_r_prog;
        logic mic_l_dig;
        logic mic_r_dig;
        logic pfilt_on;
        logic det_en;
        logic err_recover;
        logic byp_m;
        logic byp_p;
    } rapc_state_t;

endpackage
`default_nettype wire

//--- rapc_time_calc.sv
// Applied AGC time: baseline times power-of-two factor, or legacy time
// Assumes the caller registers the result; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "rapc_regs.svh"

module rapc_time_calc #(
    parameter int unsigned TW = 16
) (
    input wire logic i_is_decay,
    input wire logic [7:0] i_reg,
    input wire logic [TW-1:0] i_legacy_ms,
    input wire logic [TW-1:0] i_cap_ms,
    output logic [TW-1:0] o_time_ms
);

    // Baseline time in ms for a two-bit code
    function automatic logic [TW-1:0] base_ms(input logic dec, input logic [1:0] code);
        logic [15:0] t;
        t = `RAPC_ATT_MS_0;
        unique case ({dec, code})
            3'h0: t = `RAPC_ATT_MS_0;
            3'h1: t = `RAPC_ATT_MS_1;
            3'h2: t = `RAPC_ATT_MS_2;
            3'h3: t = `RAPC_ATT_MS_3;
            3'h4: t = `RAPC_DEC_MS_0;
            3'h5: t = `RAPC_DEC_MS_1;
            3'h6: t = `RAPC_DEC_MS_2;
            3'h7: t = `RAPC_DEC_MS_3;
        endcase
        return TW'(t);
    endfunction

    logic [TW+7:0] scaled;
    logic [TW+7:0] chosen;

    // Scale, choose source, then clamp to the cap
    always_comb begin
        scaled = {8'h00, base_ms(i_is_decay, i_reg[`RAPC_BASE_HI:`RAPC_BASE_LO])}
            << i_reg[`RAPC_MULT_HI:`RAPC_MULT_LO];
        if (i_reg[`RAPC_SEL_BIT]) begin
            chosen = scaled;
        end else begin
            chosen = {8'h00, i_legacy_ms};
        end
        if (chosen > {8'h00, i_cap_ms}) begin
            o_time_ms = i_cap_ms;
        end else begin
            o_time_ms = chosen[TW-1:0];
        end
    end

endmodule
`default_nettype wire

//--- rapc_cfg_regs.sv
// Right AGC time, ADC path, bus-condition and bypass configuration regs
// Assumes a synchronous byte register port driven by the control bus logic
//
// What this block does
// - Attack select bit picks legacy or local time
// - Attack baseline codes give 7/8/10/11 ms
// - Attack multiplier scales by two to field
// - Decay select bit picks legacy or local time
// - Decay baseline codes give 50/150/250/350 ms
// - Decay multiplier scales by two to field
// - Decay time capped by decimation ratio
// - Left high-pass uses programmable coefficients when set
// - Right high-pass uses programmable coefficients when set
// - Two-bit field picks microphone types
// - Programmable filter on ADC only with DACs down
// - Detector bit disables bus error detection
// - Bus error status set, cleared by read
// - Top bypass bits close line-2 input switches
`timescale 1ns/10ps
`default_nettype none
`include "rapc_regs.svh"

module rapc_cfg_regs #(
    parameter int unsigned TW = 16,
    parameter int unsigned RW = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [6:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic [TW-1:0] i_legacy_attack_ms,
    input wire logic [TW-1:0] i_legacy_decay_ms,
    input wire logic [RW-1:0] i_adc_decimation_ratio,
    input wire logic i_left_high_pass_stage_en,
    input wire logic i_right_high_pass_stage_en,
    input wire logic i_left_dac_pd,
    input wire logic i_right_dac_pd,
    input wire logic i_bus_error,
    output logic [TW-1:0] o_attack_ms,
    output logic [TW-1:0] o_decay_ms,
    output logic o_left_high_pass_stage_prog,
    output logic o_right_high_pass_stage_prog,
    output logic o_left_mic_digital,
    output logic o_right_mic_digital,
    output logic o_prog_filter_on_adc,
    output logic o_bus_error_detect_en,
    output logic o_bus_error_recover,
    output logic o_right_line2_minus_input_sw,
    output logic o_right_line2_plus_input_sw
);

    rapc_pkg::rapc_state_t st_q;
    rapc_pkg::rapc_state_t st_d;
    logic [TW-1:0] attack_calc;
    logic [TW-1:0] decay_calc;
    logic [TW-1:0] decay_cap;
    logic err_set;
    logic err_clr;
    rapc_pkg::rapc_mic_cfg_t mic_cfg;

    // Decay ceiling for a decimation ratio given in half steps
    function automatic logic [TW-1:0] cap_ms(input logic [RW-1:0] ratio);
        logic [15:0] c;
        c = `RAPC_CAP_R5_5;
        if (ratio <= RW'(`RAPC_DR_1)) begin
            c = `RAPC_CAP_R1;
        end else if (ratio == RW'(`RAPC_DR_1_5)) begin
            c = `RAPC_CAP_R1_5;
        end else if (ratio == RW'(`RAPC_DR_2)) begin
            c = `RAPC_CAP_R2;
        end else if (ratio == RW'(`RAPC_DR_2_5)) begin
            c = `RAPC_CAP_R2_5;
        end else if (ratio <= RW'(`RAPC_DR_3_5)) begin
            c = `RAPC_CAP_R3;
        end else if (ratio <= RW'(`RAPC_DR_4_5)) begin
            c = `RAPC_CAP_R4;
        end else if (ratio == RW'(`RAPC_DR_5)) begin
            c = `RAPC_CAP_R5;
        end
        return TW'(c);
    endfunction

    assign decay_cap = cap_ms(i_adc_decimation_ratio);

    // Attack time, never capped
    rapc_time_calc #(
        .TW(TW)
    ) u_attack (
        .i_is_decay(1'b0),
        .i_reg(st_q.attack_reg),
        .i_legacy_ms(i_legacy_attack_ms),
        .i_cap_ms(TW'(`RAPC_NOCAP)),
        .o_time_ms(attack_calc)
    );

    // Decay time, capped by decimation ratio
    rapc_time_calc #(
        .TW(TW)
    ) u_decay (
        .i_is_decay(1'b1),
        .i_reg(st_q.decay_reg),
        .i_legacy_ms(i_legacy_decay_ms),
        .i_cap_ms(decay_cap),
        .o_time_ms(decay_calc)
    );

    // Bus error events and read-to-clear
    assign err_set = i_bus_error && !st_q.path_reg[`RAPC_BUSDET_BIT];
    assign err_clr = i_reg_rd && (i_reg_addr == `RAPC_ADDR_PATH);
    assign mic_cfg = rapc_pkg::rapc_mic_cfg_t'(st_q.path_reg[`RAPC_MIC_HI:`RAPC_MIC_LO]);

    // Next state: register writes, reads, status and derived controls
    always_comb begin
        st_d = st_q;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `RAPC_ADDR_ATTACK: st_d.attack_reg = i_reg_wdata;
                `RAPC_ADDR_DECAY: st_d.decay_reg = i_reg_wdata;
                `RAPC_ADDR_PATH: st_d.path_reg = i_reg_wdata & `RAPC_PATH_WMASK;
                `RAPC_ADDR_BYPASS: st_d.bypass_reg = i_reg_wdata & `RAPC_BYPASS_WMASK;
                default: st_d.bypass_reg = st_q.bypass_reg;
            endcase
        end
        // Read data holds until the next read
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `RAPC_ADDR_ATTACK: st_d.rdata = st_q.attack_reg;
                `RAPC_ADDR_DECAY: st_d.rdata = st_q.decay_reg;
                `RAPC_ADDR_PATH: st_d.rdata = st_q.path_reg | {7'h00, st_q.err_sts};
                `RAPC_ADDR_BYPASS: st_d.rdata = st_q.bypass_reg;
                default: st_d.rdata = `RAPC_RD_NONE;
            endcase
        end
        // A new error wins over a clearing read
        st_d.err_sts = err_set || (st_q.err_sts && !err_clr);
        st_d.err_recover = err_set;
        st_d.det_en = !st_q.path_reg[`RAPC_BUSDET_BIT];
        st_d.attack_ms = attack_calc;
        st_d.decay_ms = decay_calc;
        st_d.hipass_l_prog = i_left_high_pass_stage_en && st_q.path_reg[`RAPC_HIPASS_L_BIT];
        st_d.hipass_r_prog = i_right_high_pass_stage_en && st_q.path_reg[`RAPC_HIPASS_R_BIT];
        st_d.pfilt_on = st_q.path_reg[`RAPC_PFILT_BIT] && i_left_dac_pd && i_right_dac_pd;
        st_d.byp_m = st_q.bypass_reg[`RAPC_BYP_M_BIT];
        st_d.byp_p = st_q.bypass_reg[`RAPC_BYP_P_BIT];
        // Microphone type decode
        unique case (mic_cfg)
            rapc_pkg::RAPC_MIC_DD: begin
                st_d.mic_l_dig = 1'b1;
                st_d.mic_r_dig = 1'b1;
            end
            rapc_pkg::RAPC_MIC_DA: begin
                st_d.mic_l_dig = 1'b1;
                st_d.mic_r_dig = 1'b0;
            end
            rapc_pkg::RAPC_MIC_AD: begin
                st_d.mic_l_dig = 1'b0;
                st_d.mic_r_dig = 1'b1;
            end
            rapc_pkg::RAPC_MIC_AA: begin
                st_d.mic_l_dig = 1'b0;
                st_d.mic_r_dig = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
            st_q.attack_reg <= `RAPC_RST_ATTACK;
            st_q.decay_reg <= `RAPC_RST_DECAY;
            st_q.path_reg <= `RAPC_RST_PATH;
            st_q.bypass_reg <= `RAPC_RST_BYPASS;
            st_q.det_en <= 1'b1;
            st_q.mic_l_dig <= 1'b1;
            st_q.mic_r_dig <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign o_reg_rdata = st_q.rdata;
    assign o_attack_ms = st_q.attack_ms;
    assign o_decay_ms = st_q.decay_ms;
    assign o_left_high_pass_stage_prog = st_q.hipass_l_prog;
    assign o_right_high_pass_stage_prog = st_q.hipass_r_prog;
    assign o_left_mic_digital = st_q.mic_l_dig;
    assign o_right_mic_digital = st_q.mic_r_dig;
    assign o_prog_filter_on_adc = st_q.pfilt_on;
    assign o_bus_error_detect_en = st_q.det_en;
    assign o_bus_error_recover = st_q.err_recover;
    assign o_right_line2_minus_input_sw = st_q.byp_m;
    assign o_right_line2_plus_input_sw = st_q.byp_p;

    // Checks on the design's own behaviour
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    a_attack_legacy: assert property (
        !st_q.attack_reg[`RAPC_SEL_BIT] |=> o_attack_ms == $past(i_legacy_attack_ms))
        else $error("Legacy attack time not applied");

    a_attack_base: assert property (
        st_q.attack_reg[7:2] == 6'h38 |=> o_attack_ms == TW'(`RAPC_ATT_MS_3))
        else $error("Attack baseline code 3 not 11 ms");

    a_attack_mult: assert property (
        st_q.attack_reg[7:2] == 6'h27 |=> o_attack_ms == TW'(16'h0380))
        else $error("Attack multiplier 128 wrong");

    a_decay_legacy: assert property (
        !st_q.decay_reg[`RAPC_SEL_BIT] && i_legacy_decay_ms <= TW'(`RAPC_CAP_R1)
        |=> o_decay_ms == $past(i_legacy_decay_ms))
        else $error("Legacy decay time not applied");

    a_decay_base: assert property (
        st_q.decay_reg[7:2] == 6'h38 && i_adc_decimation_ratio >= RW'(`RAPC_DR_1)
        |=> o_decay_ms == TW'(`RAPC_DEC_MS_3))
        else $error("Decay baseline code 3 not 350 ms");

    a_decay_mult: assert property (
        st_q.decay_reg[7:2] == 6'h23 && i_adc_decimation_ratio >= RW'(`RAPC_DR_1)
        |=> o_decay_ms == TW'(16'h0190))
        else $error("Decay multiplier 8 wrong");

    a_decay_cap: assert property (
        i_adc_decimation_ratio == RW'(`RAPC_DR_1) ##1 i_adc_decimation_ratio == RW'(`RAPC_DR_1)
        |=> o_decay_ms <= TW'(`RAPC_CAP_R1))
        else $error("Decay exceeds cap at ratio one");

    a_hipass_select: assert property (
        1'b1 |=> o_left_high_pass_stage_prog
        == $past(i_left_high_pass_stage_en && st_q.path_reg[`RAPC_HIPASS_L_BIT])
        && o_right_high_pass_stage_prog
        == $past(i_right_high_pass_stage_en && st_q.path_reg[`RAPC_HIPASS_R_BIT]))
        else $error("High-pass coefficient select wrong");

    a_mic_decode: assert property (
        1'b1 |=> {o_left_mic_digital, o_right_mic_digital}
        == ~$past(st_q.path_reg[`RAPC_MIC_HI:`RAPC_MIC_LO]))
        else $error("Microphone type decode wrong");

    a_pfilt_gate: assert property (
        !(i_left_dac_pd && i_right_dac_pd) |=> !o_prog_filter_on_adc)
        else $error("Programmable filter on with a DAC up");

    a_det_off: assert property (
        st_q.path_reg[`RAPC_BUSDET_BIT] |=> !o_bus_error_detect_en && !o_bus_error_recover)
        else $error("Bus error detection not disabled");

    a_err_set: assert property (
        i_bus_error && o_bus_error_detect_en && !st_q.path_reg[`RAPC_BUSDET_BIT]
        |=> st_q.err_sts && o_bus_error_recover)
        else $error("Bus error not recorded");

    a_err_clear: assert property (
        err_clr && !err_set ##1 i_reg_rd && i_reg_addr == `RAPC_ADDR_PATH && !err_set
        |=> o_reg_rdata[`RAPC_BUSERR_BIT] == 1'b0)
        else $error("Bus error status not cleared by read");

    a_rsvd_zero: assert property (
        $past(i_reg_rd) |-> !(o_reg_rdata[`RAPC_RSVD_BIT] && $past(i_reg_addr) == `RAPC_ADDR_PATH))
        else $error("Reserved status bit reads one");

    a_bypass_sw: assert property (
        i_reg_wr && i_reg_addr == `RAPC_ADDR_BYPASS
        |-> ##2 o_right_line2_minus_input_sw == $past(i_reg_wdata[`RAPC_BYP_M_BIT], 2)
        && o_right_line2_plus_input_sw == $past(i_reg_wdata[`RAPC_BYP_P_BIT], 2))
        else $error("Bypass switch does not follow write");

    // Read data, ceilings, enables and sticky status
    a_attack_rdback: assert property (
        i_reg_rd && i_reg_addr == `RAPC_ADDR_ATTACK |=> o_reg_rdata == $past(st_q.attack_reg))
        else $error("Attack register read back wrong");

    a_decay_rdback: assert property (
        i_reg_rd && i_reg_addr == `RAPC_ADDR_DECAY |=> o_reg_rdata == $past(st_q.decay_reg))
        else $error("Decay register read back wrong");

    a_decay_top_cap: assert property (
        st_q.decay_reg[7:2] == 6'h3f && i_adc_decimation_ratio > RW'(`RAPC_DR_5) |=> o_decay_ms == TW'(`RAPC_CAP_R5_5))
        else $error("Longest decay not held at top ceiling");

    a_decay_cap_five: assert property (
        i_adc_decimation_ratio == RW'(`RAPC_DR_5) |=> o_decay_ms <= TW'(`RAPC_CAP_R5))
        else $error("Decay exceeds cap at ratio five");

    a_hipass_left_off: assert property (
        !i_left_high_pass_stage_en |=> !o_left_high_pass_stage_prog)
        else $error("Left programmable coefficients with high-pass off");

    a_hipass_right_off: assert property (
        !i_right_high_pass_stage_en |=> !o_right_high_pass_stage_prog)
        else $error("Right programmable coefficients with high-pass off");

    a_pfilt_attach: assert property (
        st_q.path_reg[`RAPC_PFILT_BIT] && i_left_dac_pd && i_right_dac_pd |=> o_prog_filter_on_adc)
        else $error("Programmable filter not attached with DACs down");

    a_recover_only: assert property (
        !i_bus_error |=> !o_bus_error_recover)
        else $error("Recover pulse without a bus error");

    a_status_read: assert property (
        i_reg_rd && i_reg_addr == `RAPC_ADDR_PATH |=> o_reg_rdata[`RAPC_BUSERR_BIT] == $past(st_q.err_sts))
        else $error("Bus error status not reported on read");

    a_err_hold: assert property (
        st_q.err_sts && !err_clr |=> st_q.err_sts)
        else $error("Bus error status lost before a read");

    a_err_quiet: assert property (
        !st_q.err_sts && !i_bus_error |=> !st_q.err_sts)
        else $error("Bus error status set without an error");

    a_err_off: assert property (
        st_q.path_reg[`RAPC_BUSDET_BIT] && !st_q.err_sts |=> !st_q.err_sts)
        else $error("Bus error status set with detector off");

    a_bypass_rdback: assert property (
        i_reg_rd && i_reg_addr == `RAPC_ADDR_BYPASS
        |=> o_reg_rdata == $past(st_q.bypass_reg) && (o_reg_rdata & ~`RAPC_BYPASS_WMASK) == 8'h00)
        else $error("Bypass register read back wrong");

    // Main scenarios
    c_local_attack: cover property (
        st_q.attack_reg[`RAPC_SEL_BIT] ##1 o_attack_ms > TW'(`RAPC_ATT_MS_3));
    c_decay_capped: cover property (
        st_q.decay_reg[`RAPC_SEL_BIT] ##1 o_decay_ms == TW'(`RAPC_CAP_R1));
    c_err_read: cover property (
        st_q.err_sts && err_clr ##1 o_reg_rdata[`RAPC_BUSERR_BIT]);
    c_pfilt: cover property (o_prog_filter_on_adc);
    c_err_ignored: cover property (
        st_q.path_reg[`RAPC_BUSDET_BIT] && i_bus_error);

endmodule
`default_nettype wire

//--- rapc_cfg_regs_tb_top.sv
// Self-checking bench for the right AGC time, ADC path and bypass registers
// Assumes the design files and rapc_regs.svh are compiled before this file
`timescale 1ns/10ps
`default_nettype none
`include "rapc_regs.svh"

module rapc_cfg_regs_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [15:0] legacy_attack = 16'h0123;
    logic [15:0] legacy_decay = 16'h2000;
    logic [3:0] dec_ratio = 4'h2;
    logic hp_l_en = 1'b1;
    logic hp_r_en = 1'b1;
    logic left_dac_pd = 1'b1;
    logic right_dac_pd = 1'b1;
    logic bus_err = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] attack_ms;
    logic [15:0] decay_ms;
    logic hp_l_prog;
    logic hp_r_prog;
    logic mic_l_dig;
    logic mic_r_dig;
    logic pfilt;
    logic det_en;
    logic recover;
    logic sw_m;
    logic sw_p;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] att_tab [4] = '{`RAPC_ATT_MS_0, `RAPC_ATT_MS_1, `RAPC_ATT_MS_2, `RAPC_ATT_MS_3};
    logic [15:0] dec_tab [4] = '{`RAPC_DEC_MS_0, `RAPC_DEC_MS_1, `RAPC_DEC_MS_2, `RAPC_DEC_MS_3};

    rapc_cfg_regs dut (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata),
        .i_legacy_attack_ms(legacy_attack),
        .i_legacy_decay_ms(legacy_decay),
        .i_adc_decimation_ratio(dec_ratio),
        .i_left_high_pass_stage_en(hp_l_en),
        .i_right_high_pass_stage_en(hp_r_en),
        .i_left_dac_pd(left_dac_pd),
        .i_right_dac_pd(right_dac_pd),
        .i_bus_error(bus_err),
        .o_attack_ms(attack_ms),
        .o_decay_ms(decay_ms),
        .o_left_high_pass_stage_prog(hp_l_prog),
        .o_right_high_pass_stage_prog(hp_r_prog),
        .o_left_mic_digital(mic_l_dig),
        .o_right_mic_digital(mic_r_dig),
        .o_prog_filter_on_adc(pfilt),
        .o_bus_error_detect_en(det_en),
        .o_bus_error_recover(recover),
        .o_right_line2_minus_input_sw(sw_m),
        .o_right_line2_plus_input_sw(sw_p)
    );

    // Clock, 10 ns period
    always #5 i_clk_sys = ~i_clk_sys;

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare of a register read
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare of a derived output, single bits packed into the low end
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One write strobe; the data and address hold through the taking edge
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        reg_wr <= 1'b0;
    endtask

    // One read strobe; data is taken one cycle after the taking edge
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        reg_rd <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        chk_byte(reg_rdata, exp);
    endtask

    // Lets derived outputs follow a write or an input change
    task automatic settle();
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    // One-cycle bus error pulse; returns just after the answering edge
    task automatic err_pulse();
        @(posedge i_clk_sys);
        bus_err <= 1'b1;
        @(posedge i_clk_sys);
        bus_err <= 1'b0;
        #1;
    endtask

    // Decay ceiling by decimation ratio, ratio given in half steps
    function automatic logic [15:0] cap_ms(input logic [3:0] r);
        case (r)
            4'h0, 4'h1, 4'h2: cap_ms = `RAPC_CAP_R1;
            4'h3: cap_ms = `RAPC_CAP_R1_5;
            4'h4: cap_ms = `RAPC_CAP_R2;
            4'h5: cap_ms = `RAPC_CAP_R2_5;
            4'h6, 4'h7: cap_ms = `RAPC_CAP_R3;
            4'h8, 4'h9: cap_ms = `RAPC_CAP_R4;
            4'ha: cap_ms = `RAPC_CAP_R5;
            default: cap_ms = `RAPC_CAP_R5_5;
        endcase
    endfunction

    // Baseline times two to the multiplier, limited by the ceiling
    function automatic logic [15:0] scaled(input logic [15:0] base, input int m, input logic [15:0] cap);
        logic [23:0] t;
        t = {8'h00, base} << m;
        scaled = (t > {8'h00, cap}) ? cap : t[15:0];
    endfunction

    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        settle();
        chk_out(attack_ms, legacy_attack);
        chk_out(decay_ms, `RAPC_CAP_R1);
        chk_out({14'h0000, mic_l_dig, mic_r_dig}, 16'h0003);
        chk_out({15'h0000, det_en}, 16'h0001);
        rd_chk(`RAPC_ADDR_ATTACK, `RAPC_RST_ATTACK);
        rd_chk(`RAPC_ADDR_DECAY, `RAPC_RST_DECAY);
        rd_chk(`RAPC_ADDR_PATH, `RAPC_RST_PATH);
        rd_chk(`RAPC_ADDR_BYPASS, `RAPC_RST_BYPASS);
        // Attack: every baseline and multiplier, reserved bits written as zeros
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m++) begin
                reg_write(`RAPC_ADDR_ATTACK, {1'b1, 2'(b), 3'(m), 2'b00});
                settle();
                chk_out(attack_ms, scaled(att_tab[b], m, `RAPC_NOCAP));
            end
        end
        rd_chk(`RAPC_ADDR_ATTACK, 8'hfc);
        reg_write(`RAPC_ADDR_ATTACK, 8'h7c);
        @(posedge i_clk_sys);
        legacy_attack <= 16'h0456;
        settle();
        chk_out(attack_ms, 16'h0456);
        // Decay: every baseline and multiplier under the largest ceiling
        @(posedge i_clk_sys);
        dec_ratio <= 4'hc;
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m++) begin
                reg_write(`RAPC_ADDR_DECAY, {1'b1, 2'(b), 3'(m), 2'b00});
                settle();
                chk_out(decay_ms, scaled(dec_tab[b], m, cap_ms(4'hc)));
            end
        end
        // Longest decay against every ratio code
        for (int r = 0; r < 16; r++) begin
            @(posedge i_clk_sys);
            dec_ratio <= 4'(r);
            settle();
            chk_out(decay_ms, cap_ms(4'(r)));
        end
        reg_write(`RAPC_ADDR_DECAY, 8'h7c);
        settle();
        chk_out(decay_ms, 16'h2000);
        @(posedge i_clk_sys);
        legacy_decay <= 16'hf000;
        settle();
        chk_out(decay_ms, `RAPC_CAP_R5_5);
        // Path: coefficient selects, microphone codes, filter attach
        for (int c = 0; c < 4; c++) begin
            reg_write(`RAPC_ADDR_PATH, {2'b11, 2'(c), 4'h8});
            settle();
            chk_out({12'h000, hp_l_prog, hp_r_prog, mic_l_dig, mic_r_dig}, {12'h000, 2'b11, ~c[1], ~c[0]});
            chk_out({15'h0000, pfilt}, 16'h0001);
            rd_chk(`RAPC_ADDR_PATH, {2'b11, 2'(c), 4'h8});
        end
        @(posedge i_clk_sys);
        right_dac_pd <= 1'b0;
        hp_l_en <= 1'b0;
        settle();
        chk_out({15'h0000, pfilt}, 16'h0000);
        chk_out({14'h0000, hp_l_prog, hp_r_prog}, 16'h0001);
        @(posedge i_clk_sys);
        right_dac_pd <= 1'b1;
        hp_l_en <= 1'b1;
        reg_write(`RAPC_ADDR_PATH, 8'h00);
        settle();
        chk_out({14'h0000, hp_l_prog, hp_r_prog}, 16'h0000);
        chk_out({15'h0000, pfilt}, 16'h0000);
        // Bus error with detector on: recover pulse, sticky status, read clears
        err_pulse();
        chk_out({15'h0000, recover}, 16'h0001);
        @(posedge i_clk_sys);
        #1;
        chk_out({15'h0000, recover}, 16'h0000);
        rd_chk(`RAPC_ADDR_PATH, 8'h01);
        rd_chk(`RAPC_ADDR_PATH, 8'h00);
        // Detector off: errors ignored
        reg_write(`RAPC_ADDR_PATH, 8'h04);
        settle();
        chk_out({15'h0000, det_en}, 16'h0000);
        err_pulse();
        chk_out({15'h0000, recover}, 16'h0000);
        rd_chk(`RAPC_ADDR_PATH, 8'h04);
        reg_write(`RAPC_ADDR_PATH, 8'hff);
        rd_chk(`RAPC_ADDR_PATH, 8'hfc);
        // Bypass switches
        reg_write(`RAPC_ADDR_BYPASS, 8'hff);
        settle();
        chk_out({14'h0000, sw_m, sw_p}, 16'h0003);
        rd_chk(`RAPC_ADDR_BYPASS, 8'hc0);
        reg_write(`RAPC_ADDR_BYPASS, 8'h40);
        settle();
        chk_out({14'h0000, sw_m, sw_p}, 16'h0001);
        // Unmapped offset: write ignored, read gives zero
        reg_write(7'h6d, 8'haa);
        rd_chk(7'h6d, `RAPC_RD_NONE);
        rd_chk(`RAPC_ADDR_BYPASS, 8'h40);
        report_and_stop();
    end
endmodule

`default_nettype wire
